// *** em_pkg.sv ***
package em_pkg;

  // ==========================================================
  // Register addresses (five-bit command address field)
  localparam logic [4:0] EM_ADDR_WAVE = 5'h01;
  localparam logic [4:0] EM_ADDR_AE = 5'h02;
  localparam logic [4:0] EM_ADDR_AE_RC = 5'h03;
  localparam logic [4:0] EM_ADDR_AE_LC = 5'h04;
  localparam logic [4:0] EM_ADDR_VA = 5'h05;
  localparam logic [4:0] EM_ADDR_VA_RC = 5'h06;
  localparam logic [4:0] EM_ADDR_VA_LC = 5'h07;
  localparam logic [4:0] EM_ADDR_VAR_LC = 5'h08;
  localparam logic [4:0] EM_ADDR_MODE = 5'h09;
  localparam logic [4:0] EM_ADDR_MASK = 5'h0a;
  localparam logic [4:0] EM_ADDR_FLAGS = 5'h0b;
  localparam logic [4:0] EM_ADDR_FLAGS_RC = 5'h0c;
  localparam logic [4:0] EM_ADDR_CH1OFS = 5'h0d;
  localparam logic [4:0] EM_ADDR_CH2OFS = 5'h0e;
  localparam logic [4:0] EM_ADDR_AMP = 5'h0f;

  // ==========================================================
  // Transfer lengths in bits
  localparam logic [4:0] EM_BITS_CMD = 5'd8;
  localparam logic [4:0] EM_BITS_24 = 5'd24;
  localparam logic [4:0] EM_BITS_16 = 5'd16;
  localparam logic [4:0] EM_BITS_8 = 5'd8;

  // ==========================================================
  // Reset values
  localparam logic [15:0] EM_MODE_RST = 16'h000c;
  localparam logic [15:0] EM_MASK_RST = 16'h0040;
  localparam logic [7:0] EM_CH1OFS_RST = 8'h00;
  localparam logic [7:0] EM_CH2OFS_RST = 8'h00;
  localparam logic [7:0] EM_AMP_RST = 8'h00;

  // ==========================================================
  // Field positions
  localparam int EM_CMD_WR_BIT = 7;
  localparam int EM_WAVE_SEL_HI = 14;
  localparam int EM_WAVE_SEL_LO = 13;
  localparam int EM_INTEG_BIT = 7;
  localparam logic [7:0] EM_CH1OFS_MASK = 8'hbf;
  localparam logic [7:0] EM_CH2OFS_MASK = 8'h3f;

  // Waveform source codes in the mode select field
  localparam logic [1:0] EM_WAVE_POWER = 2'h0;
  localparam logic [1:0] EM_WAVE_CH1 = 2'h2;
  localparam logic [1:0] EM_WAVE_CH2 = 2'h3;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {EM_ST_IDLE, EM_ST_CMD, EM_ST_WRITE, EM_ST_READ} em_state_t;

  typedef struct packed {
    logic [23:0] ch1;
    logic [23:0] ch2;
    logic [23:0] active;
    logic [23:0] apparent;
    logic [23:0] reactive;
    logic sample_stb;
    logic half_cycle_stb;
  } em_meas_t;

  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] irq_mask;
    logic integrator_en;
    logic [5:0] ch1_offset;
    logic [5:0] ch2_offset;
    logic [7:0] amp_gain;
  } em_cfg_t;

endpackage : em_pkg

// *** em_sync.sv ***
`timescale 1ns/1ns

// Two-flop synchroniser, one stage pair per bit
module em_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  // ==========================================================
  // Per-bit stages; the first flop feeds only the second
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta_r;
      always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
          meta_r <= RST[g];
          sync_o[g] <= RST[g];
        end else begin
          meta_r <= async_i[g];
          sync_o[g] <= meta_r;
        end
      end
    end
  endgenerate

endmodule : em_sync

// *** em_bank.sv ***
`timescale 1ns/1ns

// Operation
// RULE_01 - Waveform register loads ch1, ch2 or power, chosen by mode bits 14:13.
// RULE_02 - Active power integrates into a 24-bit read-only active energy register.
// RULE_03 - Read-clear active energy view returns the same value, then zeroes it.
// RULE_04 - Read-clear apparent energy view returns apparent energy, then zeroes it.
// RULE_05 - Line-cycle active energy accumulates over programmed half line cycles.
// RULE_06 - Line-cycle apparent energy accumulates over programmed half cycles, read-only.
// RULE_07 - Line-cycle reactive energy accumulates over programmed half cycles, read-only.
// RULE_08 - 16-bit read/write mode register resets to 000c, readable any time.
// RULE_09 - Masked events still set flags but do not drive interrupt; mask resets 40.
// RULE_10 - Read-only status register flags identify each interrupt source.
// RULE_11 - Read-clear status view returns flags, then clears them all.
// RULE_12 - Channel-1 offset MSB enables integrator; bit 6 unused; low bits offset.
// RULE_13 - Channel-2 offset uses bits 0 to 5, ignores bits 6 and 7.
// RULE_14 - 8-bit read/write gain register selects amplifier gain of both channels.
// RULE_15 - Each access opens with command byte: MSB write flag, 5 LSBs address.
// RULE_16 - Data moves MSB first in whole bytes, right-justified, upper bits ignored.
// RULE_17 - A read captures the whole register into the shift path at once.
// RULE_18 - Writes to read-only registers are ignored and leave accumulation untouched.
module em_bank (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Serial pins
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic cs_n_i,
  output logic dout_o,
  output logic dout_oe_n_o,
  // Measurement path
  input wire em_pkg::em_meas_t meas_i,
  input wire logic [15:0] event_i,
  input wire logic [14:0] half_cycle_count_i,
  // Configuration and interrupt
  output em_pkg::em_cfg_t cfg_o,
  output logic irq_o,
  output logic irq_oe_n_o
);
  import em_pkg::*;

  // ==========================================================
  // Pin synchronisation and edge detection
  logic [2:0] pins_s;
  logic sclk_s;
  logic din_s;
  logic cs_n_s;
  logic sclk_prev_r;
  logic cs_prev_r;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;

  em_sync #(
    .W(3),
    .RST(3'h5)
  ) u_sync (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .async_i({sclk_i, din_i, cs_n_i}),
    .sync_o(pins_s)
  );

  assign sclk_s = pins_s[2];
  assign din_s = pins_s[1];
  assign cs_n_s = pins_s[0];

  // Previous levels for edge finding; idle high on both
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_prev_r <= 1'b1;
      cs_prev_r <= 1'b1;
    end else begin
      sclk_prev_r <= sclk_s;
      cs_prev_r <= cs_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_r & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_prev_r & ~cs_n_s;
  assign cs_fall = ~cs_n_s & cs_prev_r;

  // ==========================================================
  // Serial state
  em_state_t state_r;
  logic [4:0] cnt_r;
  logic [6:0] cmd_sh_r;
  logic [4:0] addr_r;
  logic [23:0] wr_sh_r;
  logic [23:0] rd_sh_r;
  logic [7:0] cmd_byte;
  logic [4:0] cur_len;
  logic [23:0] rd_val;
  logic [23:0] rd_aligned;
  logic last_bit;
  logic wr_commit;
  logic rd_done;
  logic [23:0] wr_word;

  // Transfer length of a register, unmapped ones take one byte
  function automatic logic [4:0] reg_len(input logic [4:0] a);
    if (a >= EM_ADDR_WAVE && a <= EM_ADDR_VAR_LC) begin
      reg_len = EM_BITS_24;
    end else if (a >= EM_ADDR_MODE && a <= EM_ADDR_FLAGS_RC) begin
      reg_len = EM_BITS_16;
    end else begin
      reg_len = EM_BITS_8;
    end
  endfunction : reg_len

  assign cmd_byte = {cmd_sh_r, din_s};
  assign cur_len = reg_len(addr_r);
  assign last_bit = (cnt_r == cur_len - 5'd1);
  assign wr_commit = sclk_fall & (state_r == EM_ST_WRITE) & last_bit;
  assign rd_done = sclk_fall & (state_r == EM_ST_READ) & last_bit;
  // The last bit is still on din at the commit edge, so fold it in here
  assign wr_word = {wr_sh_r[22:0], din_s};

  // Right-justified value moved up so its MSB leaves first
  always_comb begin
    rd_aligned = rd_val;
    if (reg_len(cmd_byte[4:0]) == EM_BITS_16) begin
      rd_aligned = {rd_val[15:0], 8'h00};
    end else if (reg_len(cmd_byte[4:0]) == EM_BITS_8) begin
      rd_aligned = {rd_val[7:0], 16'h0000};
    end
  end

  // Command, write and read sequencing; a chip-select fall restarts command mode
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= EM_ST_CMD;
      cnt_r <= 5'd0;
      cmd_sh_r <= 7'h00;
      addr_r <= 5'h00;
    end else if (cs_n_s) begin
      state_r <= EM_ST_IDLE;
      cnt_r <= 5'd0;
    end else if (cs_fall) begin
      state_r <= EM_ST_CMD;
      cnt_r <= 5'd0;
    end else if (sclk_fall) begin
      cnt_r <= cnt_r + 5'd1;
      case (state_r)
        EM_ST_CMD: begin
          cmd_sh_r <= cmd_byte[6:0];
          if (cnt_r == EM_BITS_CMD - 5'd1) begin
            addr_r <= cmd_byte[4:0]; // [RULE_15]
            cnt_r <= 5'd0;
            state_r <= cmd_byte[EM_CMD_WR_BIT] ? EM_ST_WRITE : EM_ST_READ; // [RULE_15]
          end
        end
        EM_ST_WRITE, EM_ST_READ: begin
          if (last_bit) begin
            state_r <= EM_ST_CMD;
            cnt_r <= 5'd0;
          end
        end
        default: begin
          state_r <= EM_ST_CMD;
          cnt_r <= 5'd0;
        end
      endcase
    end
  end

  // Write data, MSB first
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_sh_r <= 24'h000000;
    end else if (sclk_fall && state_r == EM_ST_WRITE) begin
      wr_sh_r <= {wr_sh_r[22:0], din_s}; // [RULE_16]
    end
  end

  // Read path: whole register captured as the command byte ends
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_sh_r <= 24'h000000;
      dout_o <= 1'b0;
      dout_oe_n_o <= 1'b1;
    end else if (cs_n_s || cs_fall) begin
      dout_oe_n_o <= 1'b1;
    end else if (sclk_fall && state_r == EM_ST_CMD && cnt_r == EM_BITS_CMD - 5'd1
                 && !cmd_byte[EM_CMD_WR_BIT]) begin
      rd_sh_r <= rd_aligned; // [RULE_17] [RULE_16]
    end else if (sclk_rise && state_r == EM_ST_READ) begin
      dout_o <= rd_sh_r[23]; // [RULE_16]
      rd_sh_r <= {rd_sh_r[22:0], 1'b0};
      dout_oe_n_o <= 1'b0;
    end else if (rd_done) begin
      dout_oe_n_o <= 1'b1; // Release on the falling edge of the last pulse
    end
  end

  // ==========================================================
  // Writable registers; read-only addresses have no write path
  logic [15:0] mode_r;
  logic [15:0] mask_r;
  logic [7:0] ch1ofs_r;
  logic [7:0] ch2ofs_r;
  logic [7:0] amp_r;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_r <= EM_MODE_RST; // [RULE_08]
      mask_r <= EM_MASK_RST; // [RULE_09]
      ch1ofs_r <= EM_CH1OFS_RST;
      ch2ofs_r <= EM_CH2OFS_RST;
      amp_r <= EM_AMP_RST;
    end else if (wr_commit) begin
      case (addr_r)
        EM_ADDR_MODE: mode_r <= wr_word[15:0]; // [RULE_08]
        EM_ADDR_MASK: mask_r <= wr_word[15:0]; // [RULE_09]
        EM_ADDR_CH1OFS: ch1ofs_r <= wr_word[7:0] & EM_CH1OFS_MASK; // [RULE_12]
        EM_ADDR_CH2OFS: ch2ofs_r <= wr_word[7:0] & EM_CH2OFS_MASK; // [RULE_13]
        EM_ADDR_AMP: amp_r <= wr_word[7:0]; // [RULE_14]
        default: begin
          // Read-only or unmapped: dropped [RULE_18]
        end
      endcase
    end
  end

  // Settings handed to the analogue and filter paths
  always_comb begin
    cfg_o.mode = mode_r;
    cfg_o.irq_mask = mask_r;
    cfg_o.integrator_en = ch1ofs_r[EM_INTEG_BIT]; // [RULE_12]
    cfg_o.ch1_offset = ch1ofs_r[5:0]; // [RULE_12]
    cfg_o.ch2_offset = ch2ofs_r[5:0]; // [RULE_13]
    cfg_o.amp_gain = amp_r; // [RULE_14]
  end

  // ==========================================================
  // Energy accumulators
  logic [23:0] ae_r;
  logic [23:0] va_r;
  logic ae_clr;
  logic va_clr;

  // Read-clear takes effect once the last data bit has left
  assign ae_clr = rd_done & (addr_r == EM_ADDR_AE_RC);
  assign va_clr = rd_done & (addr_r == EM_ADDR_VA_RC);

  // A sample arriving with the clear starts the fresh total, so none is lost
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ae_r <= 24'h000000;
      va_r <= 24'h000000;
    end else begin
      if (ae_clr) begin
        ae_r <= meas_i.sample_stb ? meas_i.active : 24'h000000; // [RULE_03]
      end else if (meas_i.sample_stb) begin
        ae_r <= ae_r + meas_i.active; // [RULE_02]
      end
      if (va_clr) begin
        va_r <= meas_i.sample_stb ? meas_i.apparent : 24'h000000; // [RULE_04]
      end else if (meas_i.sample_stb) begin
        va_r <= va_r + meas_i.apparent;
      end
    end
  end

  // ==========================================================
  // Line-cycle accumulation
  logic [14:0] hc_cnt_r;
  logic [23:0] lae_work_r;
  logic [23:0] lva_work_r;
  logic [23:0] lvar_work_r;
  logic [23:0] lae_r;
  logic [23:0] lva_r;
  logic [23:0] lvar_r;
  logic [23:0] lae_next;
  logic [23:0] lva_next;
  logic [23:0] lvar_next;
  logic period_end;

  // Working sums including the sample of this cycle
  always_comb begin
    lae_next = lae_work_r;
    lva_next = lva_work_r;
    lvar_next = lvar_work_r;
    if (meas_i.sample_stb) begin
      lae_next = lae_work_r + meas_i.active;
      lva_next = lva_work_r + meas_i.apparent;
      lvar_next = lvar_work_r + meas_i.reactive;
    end
  end

  // A count of zero is treated as one half cycle
  assign period_end = meas_i.half_cycle_stb && (hc_cnt_r + 15'd1 >= half_cycle_count_i);

  // Half-cycle counter
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hc_cnt_r <= 15'd0;
    end else if (period_end) begin
      hc_cnt_r <= 15'd0;
    end else if (meas_i.half_cycle_stb) begin
      hc_cnt_r <= hc_cnt_r + 15'd1;
    end
  end

  // Sums restart at each period end; results hold until the next
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lae_work_r <= 24'h000000;
      lva_work_r <= 24'h000000;
      lvar_work_r <= 24'h000000;
      lae_r <= 24'h000000;
      lva_r <= 24'h000000;
      lvar_r <= 24'h000000;
    end else if (period_end) begin
      lae_r <= lae_next; // [RULE_05]
      lva_r <= lva_next; // [RULE_06]
      lvar_r <= lvar_next; // [RULE_07]
      lae_work_r <= 24'h000000;
      lva_work_r <= 24'h000000;
      lvar_work_r <= 24'h000000;
    end else begin
      lae_work_r <= lae_next; // [RULE_05]
      lva_work_r <= lva_next; // [RULE_06]
      lvar_work_r <= lvar_next; // [RULE_07]
    end
  end

  // ==========================================================
  // Sampled waveform
  logic [23:0] wave_r;

  // Unused select code holds the previous sample
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wave_r <= 24'h000000;
    end else if (meas_i.sample_stb) begin
      case (mode_r[EM_WAVE_SEL_HI:EM_WAVE_SEL_LO])
        EM_WAVE_POWER: wave_r <= meas_i.active; // [RULE_01]
        EM_WAVE_CH1: wave_r <= meas_i.ch1; // [RULE_01]
        EM_WAVE_CH2: wave_r <= meas_i.ch2; // [RULE_01]
        default: wave_r <= wave_r;
      endcase
    end
  end

  // ==========================================================
  // Status flags and interrupt line
  logic [15:0] flags_r;
  logic flags_clr;

  assign flags_clr = rd_done & (addr_r == EM_ADDR_FLAGS_RC);

  // Events set flags whatever the mask; an event in the clearing cycle survives
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags_r <= 16'h0000;
    end else if (flags_clr) begin
      flags_r <= event_i; // [RULE_11] [RULE_09]
    end else begin
      flags_r <= flags_r | event_i; // [RULE_10] [RULE_09]
    end
  end

  // Open-drain, active low: enable pulls the wire low
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_oe_n_o <= 1'b1;
    end else begin
      irq_oe_n_o <= ~|(flags_r & mask_r); // [RULE_09]
    end
  end

  assign irq_o = 1'b0;

  // ==========================================================
  // Read value mux; the same storage backs each read-clear view
  always_comb begin
    case (cmd_byte[4:0])
      EM_ADDR_WAVE: rd_val = wave_r; // [RULE_01]
      EM_ADDR_AE, EM_ADDR_AE_RC: rd_val = ae_r; // [RULE_02] [RULE_03]
      EM_ADDR_AE_LC: rd_val = lae_r;
      EM_ADDR_VA, EM_ADDR_VA_RC: rd_val = va_r; // [RULE_04]
      EM_ADDR_VA_LC: rd_val = lva_r;
      EM_ADDR_VAR_LC: rd_val = lvar_r;
      EM_ADDR_MODE: rd_val = {8'h00, mode_r}; // [RULE_08]
      EM_ADDR_MASK: rd_val = {8'h00, mask_r};
      EM_ADDR_FLAGS, EM_ADDR_FLAGS_RC: rd_val = {8'h00, flags_r}; // [RULE_10] [RULE_11]
      EM_ADDR_CH1OFS: rd_val = {16'h0000, ch1ofs_r};
      EM_ADDR_CH2OFS: rd_val = {16'h0000, ch2ofs_r};
      EM_ADDR_AMP: rd_val = {16'h0000, amp_r};
      default: rd_val = 24'h000000;
    endcase
  end

endmodule : em_bank

// *** em_host.sv ***
`timescale 1ns/1ns

// ==========================================================
// Host side of the serial link, bit-banged at 125 ns per bit
module em_host (
  // Serial pins
  output logic sclk_o,
  output logic din_o,
  output logic cs_n_o,
  input wire logic dout_i,
  input wire logic dout_oe_n_i
);
  // Idle: clock parked high, chip deselected
  initial begin
    sclk_o = 1'b1;
    din_o = 1'b0;
    cs_n_o = 1'b1;
  end

  // Command byte then n data bits; stops after k bits to model an abort
  task automatic xfer(input logic [7:0] cmd, input int n, input logic [23:0] wd, input int k,
      output logic [23:0] rd);
    logic [31:0] sh;
    sh = {cmd, wd << (24 - n)};
    rd = '0;
    cs_n_o = 1'b0;
    for (int i = 0; i < k; i++) begin
      din_o = sh[31 - i];
      #62;
      // A released output reads back as the inverse, never as a lucky match
      if (i >= 8) rd = {rd[22:0], dout_oe_n_i ? ~dout_i : dout_i};
      sclk_o = 1'b0;
      #63;
      sclk_o = 1'b1;
    end
    din_o = ~din_o;
  endtask : xfer

  // Deselect ends or aborts a transfer
  task automatic release_cs();
    #62;
    cs_n_o = 1'b1;
    #62;
  endtask : release_cs
endmodule : em_host

// *** em_bank_assertions.sv ***
`timescale 1ns/1ns

// ==========================================================
// Port-level checks of the register bank
module em_bank_chk (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Serial pins
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic cs_n_i,
  input wire logic dout_o,
  input wire logic dout_oe_n_o,
  // Measurement path
  input wire em_pkg::em_meas_t meas_i,
  input wire logic [15:0] event_i,
  input wire logic [14:0] half_cycle_count_i,
  // Configuration and interrupt
  input wire em_pkg::em_cfg_t cfg_o,
  input wire logic irq_o,
  input wire logic irq_oe_n_o
);
  import em_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  // Deselect held long enough to clear the synchroniser
  sequence cs_idle;
    cs_n_i [*6];
  endsequence
  // Serial clock rose a few cycles ago, after a low phase
  sequence rise_seen;
    $past(sclk_i, 2) && !$past(sclk_i, 7);
  endsequence

  a_irq_data_low: assert property (irq_o == 1'b0) else $error("irq data not low");
  a_irq_on_event: assert property (|(event_i & cfg_o.irq_mask) |-> ##[1:3] !irq_oe_n_o)
    else $error("enabled event did not assert irq");
  a_mode_reset_value: assert property ($rose(resetn_i) |->
    cfg_o.mode == EM_MODE_RST && cfg_o.irq_mask == EM_MASK_RST) else $error("bad reset config");
  a_dout_idle_off: assert property (cs_idle |-> dout_oe_n_o) else $error("dout driven while idle");
  a_cfg_idle_stable: assert property (cs_idle |-> $stable(cfg_o)) else $error("config moved");
  a_dout_after_rise: assert property (!dout_oe_n_o && $changed(dout_o) |-> rise_seen)
    else $error("dout changed without sclk rise");
  a_drive_needs_cs: assert property ($fell(dout_oe_n_o) |-> !$past(cs_n_i, 3))
    else $error("dout driven without select");
  a_drive_release: assert property ($rose(dout_oe_n_o) |-> $past(!sclk_i, 2) || $past(cs_n_i, 2))
    else $error("dout released off a fall");
endmodule : em_bank_chk

bind em_bank em_bank_chk u_chk (.clock_i(clock_i), .resetn_i(resetn_i), .sclk_i(sclk_i), .din_i(din_i),
  .cs_n_i(cs_n_i), .dout_o(dout_o), .dout_oe_n_o(dout_oe_n_o), .meas_i(meas_i), .event_i(event_i),
  .half_cycle_count_i(half_cycle_count_i), .cfg_o(cfg_o), .irq_o(irq_o), .irq_oe_n_o(irq_oe_n_o));

// *** tb_top.sv ***
`timescale 1ns/1ns

// ==========================================================
// Self-checking bench: host model on the serial pins, bench on the rest
module tb_top;
  import em_pkg::*;
  logic clock_i, resetn_i, sclk_i, din_i, cs_n_i, dout_o, dout_oe_n_o, irq_o, irq_oe_n_o;
  em_meas_t meas_i;
  logic [15:0] event_i;
  logic [14:0] half_cycle_count_i;
  em_cfg_t cfg_o;
  int err_count = 0;
  int check_count = 0;

  em_bank u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .sclk_i(sclk_i), .din_i(din_i), .cs_n_i(cs_n_i),
    .dout_o(dout_o), .dout_oe_n_o(dout_oe_n_o), .meas_i(meas_i), .event_i(event_i),
    .half_cycle_count_i(half_cycle_count_i), .cfg_o(cfg_o), .irq_o(irq_o), .irq_oe_n_o(irq_oe_n_o));
  em_host u_host (.sclk_o(sclk_i), .din_o(din_i), .cs_n_o(cs_n_i), .dout_i(dout_o), .dout_oe_n_i(dout_oe_n_o));

  // 100 MHz system clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic finish_test();
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Transfer length follows the register width
  function automatic int len(input logic [4:0] a);
    return (a inside {[1:8]}) ? 24 : (a inside {[9:12]}) ? 16 : 8;
  endfunction : len

  // Start just off a clock edge so no pin moves on a sampling edge
  task automatic rd(input logic [4:0] a, input logic [23:0] e);
    logic [23:0] d;
    @(negedge clock_i);
    #1;
    u_host.xfer({3'h0, a}, len(a), 24'h0, len(a) + 8, d);
    chk(d, e);
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [23:0] v);
    logic [23:0] d;
    @(negedge clock_i);
    #1;
    u_host.xfer({3'h4, a}, len(a), v, len(a) + 8, d);
  endtask : wr

  // One-cycle strobes on the measurement and event inputs, then settle
  task automatic pulse(input logic s, input logic h, input logic [15:0] ev);
    @(negedge clock_i);
    meas_i.sample_stb = s;
    meas_i.half_cycle_stb = h;
    event_i = ev;
    @(negedge clock_i);
    meas_i.sample_stb = 1'b0;
    meas_i.half_cycle_stb = 1'b0;
    event_i = '0;
    repeat (3) @(negedge clock_i);
  endtask : pulse

  task automatic t_reset();
    for (int a = 0; a < 16; a++) rd(5'(a), a == 9 ? 24'h000c : a == 10 ? 24'h0040 : 24'h0);
    chk(24'(cfg_o[20:0]), 24'h0);
  endtask : t_reset

  task automatic t_line();
    for (int i = 0; i < 3; i++) begin
      if (i == 2) rd(EM_ADDR_AE_LC, 24'h0);
      pulse(1'b1, 1'b0, 16'h0);
      pulse(1'b0, 1'b1, 16'h0);
    end
    wr(EM_ADDR_AE_LC, 24'hffffff);
    rd(EM_ADDR_AE_LC, 24'h33);
    rd(EM_ADDR_VA_LC, 24'h300);
    rd(EM_ADDR_VAR_LC, 24'h3000);
  endtask : t_line

  // A sample lands mid-read; the read must show the snapshot
  task automatic t_energy();
    rd(EM_ADDR_AE, 24'h33);
    wr(EM_ADDR_AE, 24'hffffff);
    fork
      rd(EM_ADDR_AE, 24'h33);
      begin #1500; pulse(1'b1, 1'b0, 16'h0); end
    join
    rd(EM_ADDR_AE_RC, 24'h44);
    rd(EM_ADDR_AE, 24'h0);
    rd(EM_ADDR_VA_RC, 24'h400);
    rd(EM_ADDR_VA, 24'h0);
  endtask : t_energy

  // Select codes in the order power, ch1, ch2, hold
  task automatic t_wave();
    logic [1:0] c;
    logic [15:0] m;
    logic [23:0] e;
    e = 24'h0;
    for (int i = 0; i < 4; i++) begin
      c = 2'(8'h78 >> (2 * i));
      m = {1'b0, c, 13'h000c};
      wr(EM_ADDR_MODE, m);
      rd(EM_ADDR_MODE, m);
      chk(cfg_o.mode, m);
      pulse(1'b1, 1'b0, 16'h0);
      if (c == EM_WAVE_POWER) e = meas_i.active;
      else if (c == EM_WAVE_CH1) e = meas_i.ch1;
      else if (c == EM_WAVE_CH2) e = meas_i.ch2;
      rd(EM_ADDR_WAVE, e);
    end
  endtask : t_wave

  task automatic t_cfg();
    wr(EM_ADDR_CH1OFS, 24'hff);
    rd(EM_ADDR_CH1OFS, 24'hbf);
    chk({cfg_o.integrator_en, cfg_o.ch1_offset}, 7'h7f);
    wr(EM_ADDR_CH2OFS, 24'hc5);
    rd(EM_ADDR_CH2OFS, 24'h05);
    chk(cfg_o.ch2_offset, 6'h05);
    wr(EM_ADDR_AMP, 24'h5a);
    rd(EM_ADDR_AMP, 24'h5a);
    chk(cfg_o.amp_gain, 8'h5a);
  endtask : t_cfg

  // Bit 0 is disabled at reset, bit 6 enabled
  task automatic t_irq();
    pulse(1'b0, 1'b0, 16'h0001);
    chk(irq_oe_n_o, 1'b1);
    rd(EM_ADDR_FLAGS, 24'h0001);
    pulse(1'b0, 1'b0, 16'h0040);
    chk(irq_oe_n_o, 1'b0);
    rd(EM_ADDR_FLAGS_RC, 24'h0041);
    rd(EM_ADDR_FLAGS, 24'h0);
    chk(irq_oe_n_o, 1'b1);
    wr(EM_ADDR_MASK, 24'h0001);
    rd(EM_ADDR_MASK, 24'h0001);
    chk(cfg_o.irq_mask, 16'h0001);
    pulse(1'b0, 1'b0, 16'h0001);
    chk(irq_oe_n_o, 1'b0);
  endtask : t_irq

  // Deselect mid-write discards it; the next select restarts command mode
  task automatic t_abort();
    logic [23:0] d;
    @(negedge clock_i);
    #1;
    u_host.xfer({3'h4, EM_ADDR_MODE}, 16, 24'hffff, 12, d);
    u_host.release_cs();
    rd(EM_ADDR_MODE, 24'h200c);
    chk(dout_oe_n_o, 1'b1);
  endtask : t_abort

  // Main sequence
  initial begin
    resetn_i = 1'b0;
    meas_i = '0;
    meas_i.ch1 = 24'h0a0b0c;
    meas_i.ch2 = 24'h0d0e0f;
    meas_i.active = 24'h11;
    meas_i.apparent = 24'h100;
    meas_i.reactive = 24'h1000;
    event_i = '0;
    half_cycle_count_i = 15'd3;
    repeat (8) @(negedge clock_i);
    resetn_i = 1'b1;
    repeat (10) @(negedge clock_i);
    t_reset();
    t_line();
    t_energy();
    t_wave();
    t_cfg();
    t_irq();
    t_abort();
    finish_test();
  end

  // Watchdog well beyond the expected run of some 200 us
  initial begin
    #800000;
    err_count++;
    finish_test();
  end
endmodule : tb_top
